// >>> hw/sps_conditioner.sv
// Purpose: Picks the setpoint source, scales, offsets, bounds and de-noises it.
// Assumes: Analog and encoder values come from logic on clk; only the pulse pin is asynchronous.
// Notes:   Registers are reached by number over a plain strobe port.
//
// Summary of operation
// - Selector 0 uses host input register.
// - Selectors 1-4 route four unsigned analog inputs.
// - Selector 5 uses the encoder count.
// - Selector 6 uses servo pulse width.
// - Multiply, divide, then add the bias.
// - Clamp between lower and upper bound.
// - Deadzone holds setpoint; zero disables it.
// - Smoothing zero passes; larger smooths more, up to 15.
// - Final setpoint is readable back.
// - Relative adjust write adds to host input.
// - Host writes the signed host input register.
// - Deadzone acts after scaling and bias.
// - Multiplier, divisor, bias at fixed numbers.
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ns
`default_nettype none
module sps_conditioner
  import sps_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output var  logic [DATA_W-1:0] rdata,
  input  wire logic [15:0]       analog_input_one,
  input  wire logic [15:0]       analog_input_two,
  input  wire logic [15:0]       analog_input_three,
  input  wire logic [15:0]       analog_input_four,
  input  wire logic [31:0]       encoder_count,
  input  wire logic              input_pin_one,
  output var  logic [31:0]       setpoint_out
);
  function automatic logic [15:0] zext16(input logic [15:0] v);
    return v;
  endfunction

  // Register file.
  sps_cfg_type cfg;
  logic [31:0] setpoint_host_input;
  logic [31:0] setpoint_relative_adjust;
  logic [15:0] setpoint_source_select;

  wire hit_rel  = wr && (addr == REG_REL_ADJUST);
  wire hit_host = wr && (addr == REG_HOST_INPUT);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      setpoint_host_input      <= RST_HOST_INPUT;
      setpoint_relative_adjust <= RST_HOST_INPUT;
      setpoint_source_select   <= RST_SOURCE_SEL;
      cfg <= '{RST_MULTIPLIER, RST_DIVISOR, RST_BIAS, RST_LOWER_BOUND,
               RST_UPPER_BOUND, RST_DEADZONE, RST_SMOOTHING};
    end else if (wr) begin
      if (hit_rel) begin
        setpoint_relative_adjust <= wdata;
        setpoint_host_input      <= setpoint_host_input + wdata;
      end
      if (hit_host) setpoint_host_input <= wdata;
      if (addr == REG_SOURCE_SEL)  setpoint_source_select <= wdata[15:0];
      if (addr == REG_MULTIPLIER)  cfg.multiplier  <= wdata[15:0];
      if (addr == REG_DIVISOR)     cfg.divisor     <= wdata[15:0];
      if (addr == REG_BIAS)        cfg.bias        <= wdata[15:0];
      if (addr == REG_LOWER_BOUND) cfg.lower_bound <= wdata;
      if (addr == REG_UPPER_BOUND) cfg.upper_bound <= wdata;
      if (addr == REG_DEADZONE)    cfg.deadzone    <= wdata[15:0];
      if (addr == REG_SMOOTHING)   cfg.smoothing   <= wdata[15:0];
    end
  end

  logic [31:0] final_sp;
  logic [31:0] next_rdata;
  always_comb begin
    unique case (addr)
      REG_REL_ADJUST:  next_rdata = setpoint_relative_adjust;
      REG_HOST_INPUT:  next_rdata = setpoint_host_input;
      REG_SOURCE_SEL:  next_rdata = {16'h0000, setpoint_source_select};
      REG_MULTIPLIER:  next_rdata = {16'h0000, cfg.multiplier};
      REG_DIVISOR:     next_rdata = {16'h0000, cfg.divisor};
      REG_BIAS:        next_rdata = {16'h0000, cfg.bias};
      REG_LOWER_BOUND: next_rdata = cfg.lower_bound;
      REG_UPPER_BOUND: next_rdata = cfg.upper_bound;
      REG_DEADZONE:    next_rdata = {16'h0000, cfg.deadzone};
      REG_SMOOTHING:   next_rdata = {16'h0000, cfg.smoothing};
      REG_FINAL:       next_rdata = final_sp;
      default:         next_rdata = 32'h0000_0000;
    endcase
  end

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rdata <= 32'h0000_0000;
    else        rdata <= rd ? next_rdata : 32'h0000_0000;
  end

  // Microsecond tick shared by pulse timing and smoothing.
  logic [7:0] tick_cnt;
  wire        tick = (tick_cnt == 8'(TICK_CYCLES - 1));
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) tick_cnt <= 8'h00;
    else        tick_cnt <= tick ? 8'h00 : tick_cnt + 8'h01;
  end

  // Pulse pin: three flops, a change counts once the last two agree.
  logic [2:0] pin_sync;
  logic       pin_level;
  logic       pin_prev;
  logic [11:0] width_us;
  logic [31:0] pulse_val;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_sync  <= 3'h0;
      pin_level <= 1'b0;
      pin_prev  <= 1'b0;
    end else begin
      pin_sync <= {pin_sync[1:0], input_pin_one};
      if (pin_sync[1] == pin_sync[2]) pin_level <= pin_sync[2];
      pin_prev <= pin_level;
    end
  end

  wire pin_rise = pin_level && !pin_prev;
  wire pin_fall = !pin_level && pin_prev;
  // Widths past the servo range are clamped so a stuck pin cannot wrap the count.
  wire width_sat = (width_us >= 12'(PULSE_MAX_US));
  wire [11:0] width_span = width_us - 12'(PULSE_MIN_US);
  wire [31:0] next_pulse_val =
    (width_us < 12'(PULSE_MIN_US)) ? 32'h0000_0000 : {20'h00000, width_span};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      width_us  <= 12'h000;
      pulse_val <= 32'h0000_0000;
    end else begin
      if (pin_rise)                         width_us <= 12'h000;
      else if (pin_level && tick && !width_sat) width_us <= width_us + 12'h001;
      if (pin_fall) pulse_val <= next_pulse_val;
    end
  end

  // Source selection.
  logic [31:0] raw;
  logic [31:0] next_raw;
  always_comb begin
    unique case (setpoint_source_select)
      SEL_REGISTER: next_raw = setpoint_host_input;
      16'h0001:     next_raw = {16'h0000, zext16(analog_input_one)};
      16'h0002:     next_raw = {16'h0000, zext16(analog_input_two)};
      16'h0003:     next_raw = {16'h0000, zext16(analog_input_three)};
      16'h0004:     next_raw = {16'h0000, zext16(analog_input_four)};
      SEL_ENCODER:  next_raw = encoder_count;
      SEL_PULSE:    next_raw = pulse_val;
      default:      next_raw = raw;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) raw <= 32'h0000_0000;
    else        raw <= next_raw;
  end

  // Scaling: a wide intermediate keeps the product exact before the divide.
  wire [15:0] div_eff = (cfg.divisor == 16'h0000) ? 16'h0001 : cfg.divisor;
  wire signed [48:0] product  = $signed(raw) * $signed({1'b0, cfg.multiplier});
  wire signed [48:0] quotient = product / $signed({33'h0, div_eff});
  wire signed [48:0] scaled   = quotient + $signed({33'h0, cfg.bias});

  wire signed [48:0] lo_ext = 49'($signed(cfg.lower_bound));
  wire signed [48:0] hi_ext = 49'($signed(cfg.upper_bound));
  wire [31:0] next_bounded =
    (scaled > hi_ext) ? cfg.upper_bound :
    (scaled < lo_ext) ? cfg.lower_bound : scaled[31:0];

  logic [31:0] bounded;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) bounded <= 32'h0000_0000;
    else        bounded <= next_bounded;
  end

  // Deadzone works on the scaled, biased and bounded value.
  logic [31:0] held;
  wire signed [32:0] dz_diff = $signed({bounded[31], bounded}) - $signed({held[31], held});
  wire [32:0] dz_mag = dz_diff[32] ? 33'(-dz_diff) : 33'(dz_diff);
  wire dz_off  = (cfg.deadzone == 16'h0000);
  wire dz_move = dz_off || (dz_mag >= {17'h00000, cfg.deadzone});

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)       held <= 32'h0000_0000;
    else if (dz_move) held <= bounded;
  end

  // First-order smoothing; a larger setting, up to 15, takes a smaller step per tick.
  wire [3:0] shift = (cfg.smoothing > 16'(SHIFT_MAX)) ? 4'(SHIFT_MAX) : cfg.smoothing[3:0];
  wire signed [32:0] f_diff = $signed({held[31], held}) - $signed({final_sp[31], final_sp});
  wire signed [32:0] f_step = f_diff >>> shift;
  wire [32:0] f_sum = 33'($signed({final_sp[31], final_sp}) + f_step);
  wire f_pass = (cfg.smoothing == 16'h0000);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)      final_sp <= 32'h0000_0000;
    else if (f_pass) final_sp <= held;
    else if (tick)   final_sp <= f_sum[31:0];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) setpoint_out <= 32'h0000_0000;
    else        setpoint_out <= final_sp;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  reg_source_a: assert property ((setpoint_source_select == SEL_REGISTER)
    |=> raw == $past(setpoint_host_input)) else $error("register source not used");
  analog_route_a: assert property ((setpoint_source_select == 16'h0003)
    |=> raw == {16'h0000, $past(analog_input_three)}) else $error("analog route wrong");
  encoder_route_a: assert property ((setpoint_source_select == SEL_ENCODER)
    |=> raw == $past(encoder_count)) else $error("encoder route wrong");
  pulse_route_a: assert property ((setpoint_source_select == SEL_PULSE)
    |=> raw <= 32'(PULSE_MAX_US - PULSE_MIN_US)) else $error("pulse value out of range");
  // A halving with a bias tells "divide then add" apart from "add then divide".
  scale_order_a: assert property ((cfg.multiplier == 16'h0001 && cfg.divisor == 16'h0002)
    |-> scaled == $signed({raw[31], raw}) / 33'sh2 + $signed({33'h0, cfg.bias}))
    else $error("scale order wrong");
  bound_clamp_a: assert property (
    $signed($past(cfg.lower_bound)) <= $signed($past(cfg.upper_bound))
    |-> $signed(bounded) >= $signed($past(cfg.lower_bound))
        && $signed(bounded) <= $signed($past(cfg.upper_bound)))
    else $error("bounded setpoint outside bounds");
  deadzone_hold_a: assert property ((!dz_off && dz_mag < {17'h00000, cfg.deadzone})
    |=> held == $past(held)) else $error("deadzone did not hold");
  filter_pass_a: assert property ((f_pass ##1 f_pass)
    |-> final_sp == $past(held)) else $error("zero smoothing not passed");
  final_read_a: assert property ((rd && addr == REG_FINAL)
    |=> rdata == $past(final_sp)) else $error("final readback wrong");
  rel_adjust_a: assert property (hit_rel
    |=> setpoint_host_input == $past(setpoint_host_input) + $past(wdata))
    else $error("relative adjust not added");
  div_zero_a: assert property ((cfg.divisor == 16'h0000)
    |-> quotient == product) else $error("zero divisor not one");
  bad_select_a: assert property ((setpoint_source_select > SEL_PULSE)
    |=> raw == $past(raw)) else $error("invalid selector changed setpoint");

  // Register writes land at the strobe's edge, so software never sees a stale value.
  host_write_a: assert property (hit_host
    |=> setpoint_host_input == $past(wdata))
    else $error("host input write lost");
  rel_write_a: assert property (hit_rel
    |=> setpoint_relative_adjust == $past(wdata))
    else $error("relative adjust write lost");
  select_write_a: assert property ((wr && addr == REG_SOURCE_SEL)
    |=> setpoint_source_select == 16'($past(wdata)))
    else $error("selector write lost");
  mult_write_a: assert property ((wr && addr == REG_MULTIPLIER)
    |=> cfg.multiplier == 16'($past(wdata)))
    else $error("multiplier write lost");
  div_write_a: assert property ((wr && addr == REG_DIVISOR)
    |=> cfg.divisor == 16'($past(wdata)))
    else $error("divisor write lost");
  bias_write_a: assert property ((wr && addr == REG_BIAS)
    |=> cfg.bias == 16'($past(wdata)))
    else $error("bias write lost");

  // Every analog route is checked, so a swapped pair of inputs shows up.
  analog_one_a: assert property ((setpoint_source_select == 16'h0001)
    |=> raw == {16'h0000, $past(analog_input_one)})
    else $error("analog one route wrong");
  analog_two_a: assert property ((setpoint_source_select == 16'h0002)
    |=> raw == {16'h0000, $past(analog_input_two)})
    else $error("analog two route wrong");
  analog_four_a: assert property ((setpoint_source_select == 16'h0004)
    |=> raw == {16'h0000, $past(analog_input_four)})
    else $error("analog four route wrong");
  // A half-settled pin must not move the level that the pulse timer sees.
  pin_filter_a: assert property ((pin_sync[1] != pin_sync[2])
    |=> pin_level == $past(pin_level))
    else $error("unsettled pin changed level");

  // The upper bound wins when both apply, so the lower one is checked without overshoot.
  clamp_high_a: assert property ((scaled > hi_ext)
    |=> bounded == $past(cfg.upper_bound))
    else $error("upper bound not applied");
  clamp_low_a: assert property ((scaled < lo_ext && !(scaled > hi_ext))
    |=> bounded == $past(cfg.lower_bound))
    else $error("lower bound not applied");
  deadzone_off_a: assert property (dz_off
    |=> held == $past(bounded))
    else $error("zero deadzone held the setpoint");
  filter_tick_a: assert property ((!f_pass && !tick)
    |=> final_sp == $past(final_sp))
    else $error("smoothing moved between ticks");
  out_follow_a: assert property (1'b1
    |=> setpoint_out == $past(final_sp))
    else $error("setpoint output not the final value");
  read_idle_a: assert property (!rd
    |=> rdata == 32'h0000_0000)
    else $error("read data outside the read cycle");

  analog_cover_c: cover property (setpoint_source_select == 16'h0001 ##1 raw != 32'h0);
  pulse_cover_c: cover property (pin_fall && width_us > 12'(PULSE_MIN_US));
  clamp_cover_c: cover property (scaled > hi_ext);
  smooth_cover_c: cover property (!f_pass && tick && f_step != 33'h0);
  deadzone_cover_c: cover property (!dz_off && !dz_move ##1 held != bounded);
endmodule // sps_conditioner
`default_nettype wire

// >>> hw/sps_pkg.sv
// Purpose: Shared constants and types for the setpoint source conditioner.
// Assumes: Register numbers are used directly as bus addresses.
// Notes:   A 32-bit register sits at its lower number; the upper number is unmapped.
`default_nettype none
package sps_pkg;
  localparam int unsigned ADDR_W = 9;
  localparam int unsigned DATA_W = 32;
  // Register numbers.
  localparam logic [8:0] REG_REL_ADJUST   = 9'h1C0;
  localparam logic [8:0] REG_HOST_INPUT   = 9'h1C2;
  localparam logic [8:0] REG_SOURCE_SEL   = 9'h1C4;
  localparam logic [8:0] REG_MULTIPLIER   = 9'h1C5;
  localparam logic [8:0] REG_DIVISOR      = 9'h1C6;
  localparam logic [8:0] REG_BIAS         = 9'h1C7;
  localparam logic [8:0] REG_LOWER_BOUND  = 9'h1C8;
  localparam logic [8:0] REG_UPPER_BOUND  = 9'h1CA;
  localparam logic [8:0] REG_DEADZONE     = 9'h1CC;
  localparam logic [8:0] REG_SMOOTHING    = 9'h1CD;
  localparam logic [8:0] REG_FINAL        = 9'h1CE;
  // Values after reset.
  localparam logic [31:0] RST_HOST_INPUT  = 32'h0000_0000;
  localparam logic [15:0] RST_SOURCE_SEL  = 16'h0000;
  localparam logic [15:0] RST_MULTIPLIER  = 16'h0001;
  localparam logic [15:0] RST_DIVISOR     = 16'h0001;
  localparam logic [15:0] RST_BIAS        = 16'h0000;
  localparam logic [31:0] RST_LOWER_BOUND = 32'h8000_0000;
  localparam logic [31:0] RST_UPPER_BOUND = 32'h7FFF_FFFF;
  localparam logic [15:0] RST_DEADZONE    = 16'h0000;
  localparam logic [15:0] RST_SMOOTHING   = 16'h0000;
  // Source selector codes.
  localparam logic [15:0] SEL_REGISTER = 16'h0000;
  localparam logic [15:0] SEL_ENCODER  = 16'h0005;
  localparam logic [15:0] SEL_PULSE    = 16'h0006;
  // Timing.
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned TICK_US       = 1;
  localparam int unsigned TICK_CYCLES   = TICK_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned PULSE_MIN_US  = 1000;
  localparam int unsigned PULSE_MAX_US  = 2000;
  localparam int unsigned SHIFT_MAX     = 15;

  typedef struct packed {
    logic [15:0] multiplier;
    logic [15:0] divisor;
    logic [15:0] bias;
    logic [31:0] lower_bound;
    logic [31:0] upper_bound;
    logic [15:0] deadzone;
    logic [15:0] smoothing;
  } sps_cfg_type;
endpackage
`default_nettype wire

// >>> test/setpoint_source_conditioner_tb_top.sv
// Purpose: Self-checking bench for the setpoint conditioner.
// Assumes: Smoothing settles in whole 1 us ticks; the pulse reading may be off by one.
// Notes:   The pulse starts after the other tests end, and waiting for it keeps the run near 100k cycles.
`timescale 1ns/1ns
`default_nettype none
module setpoint_source_conditioner_tb_top import sps_pkg::*;;
  localparam int unsigned START_US = 10;
  localparam int unsigned PULSE_US = 1003;
  localparam logic [31:0] NLO = RST_LOWER_BOUND;
  localparam logic [31:0] NHI = RST_UPPER_BOUND;
  typedef struct packed {
    logic [15:0] sel;
    logic [31:0] host;
    logic [15:0] mul;
    logic [15:0] div;
    logic [15:0] bias;
    logic [31:0] lo;
    logic [31:0] hi;
    logic [31:0] exp;
  } sps_row_type;
  localparam sps_row_type NEUTRAL = '{16'h0000, 32'h0000_0064, 16'h0001, 16'h0001, 16'h0000,
                                     NLO, NHI, 32'h0000_0064};
  localparam sps_row_type ROWS [11] = '{
    NEUTRAL,
    '{16'h0001, 32'h0, 16'h0001, 16'h0001, 16'h0000, NLO, NHI, 32'h0000_FFFF},
    '{16'h0002, 32'h0, 16'h0003, 16'h0002, 16'h0005, NLO, NHI, 32'h0000_1B53},
    '{16'h0003, 32'h0, 16'h0001, 16'h0001, 16'h0000, NLO, NHI, 32'h0000_0100},
    '{16'h0004, 32'h0, 16'h0001, 16'h0001, 16'h0000, NLO, NHI, 32'h0000_0042},
    '{16'h0005, 32'h0, 16'h0001, 16'h0001, 16'h0000, NLO, NHI, 32'hFFFF_FF00},
    '{16'h0000, 32'hFFFF_FED4, 16'h0003, 16'h0002, 16'h000A, NLO, NHI, 32'hFFFF_FE48},
    '{16'h0000, 32'h0000_0007, 16'h0002, 16'h0000, 16'h0000, NLO, NHI, 32'h0000_000E},
    '{16'h0000, 32'h0000_1388, 16'h0001, 16'h0001, 16'h0000, 32'h0, 32'h3E8, 32'h0000_03E8},
    '{16'h0000, 32'hFFFF_FFFB, 16'h0001, 16'h0001, 16'h0000, 32'h0, 32'h3E8, 32'h0000_0000},
    '{16'h0000, 32'h0000_0003, 16'h0001, 16'h0002, 16'h0002, NLO, NHI, 32'h0000_0003}};
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic              wr = 1'b0;
  logic              rd = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic [15:0]       ain [4];
  logic [31:0]       enc;
  logic              pin;
  logic [31:0]       setpoint_out;
  logic [31:0]       got;
  int                errors = 0;
  int                checks_done = 0;
  int                cycles = 0;

  always #(CLK_PERIOD_NS / 2) clk = ~clk;

  sps_far_side #(.START_US(START_US), .PULSE_US(PULSE_US)) i_sps_far_side (
    .analog_input_one(ain[0]), .analog_input_two(ain[1]), .analog_input_three(ain[2]),
    .analog_input_four(ain[3]), .encoder_count(enc), .input_pin_one(pin));

  sps_conditioner i_sps_conditioner (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .analog_input_one(ain[0]), .analog_input_two(ain[1]), .analog_input_three(ain[2]),
    .analog_input_four(ain[3]), .encoder_count(enc), .input_pin_one(pin),
    .setpoint_out(setpoint_out));

  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 115000) begin
      errors++;
      $display("FAIL timeout expected finish seen %0d cycles", cycles);
      report_and_stop;
    end
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic check_in(input string what, input logic [31:0] lo, input logic [31:0] hi,
                          input logic [31:0] seen);
    checks_done++;
    if ((seen >= lo && seen <= hi) !== 1'b1) begin
      errors++;
      $display("FAIL %s expected %h..%h seen %h", what, lo, hi, seen);
    end
  endtask

  // Strobes are not dropped here, so back-to-back writes never assign wr twice in one step.
  task automatic wr_reg(input logic [8:0] a, input logic [31:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    rd    <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_reg(input logic [8:0] a, output logic [31:0] d);
    addr <= a;
    wr   <= 1'b0;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
    @(posedge clk);
  endtask

  task automatic idle(input int n);
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (n) @(posedge clk);
  endtask

  task automatic apply(input sps_row_type r);
    wr_reg(REG_SOURCE_SEL, {16'h0000, r.sel});
    wr_reg(REG_HOST_INPUT, r.host);
    wr_reg(REG_MULTIPLIER, {16'h0000, r.mul});
    wr_reg(REG_DIVISOR, {16'h0000, r.div});
    wr_reg(REG_BIAS, {16'h0000, r.bias});
    wr_reg(REG_LOWER_BOUND, r.lo);
    wr_reg(REG_UPPER_BOUND, r.hi);
    idle(8);
  endtask

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    wr_reg(REG_FINAL, 32'h0000_0055);
    wr_reg(9'h1C1, 32'h0000_0055);
    rd_reg(REG_FINAL, got);
    check("final read-only", 32'h0000_0000, got);
    rd_reg(9'h1C1, got);
    check("unmapped word", 32'h0000_0000, got);
    rd_reg(REG_SOURCE_SEL, got);
    check("selector reset", {16'h0000, RST_SOURCE_SEL}, got);
    rd_reg(REG_MULTIPLIER, got);
    check("multiplier reset", {16'h0000, RST_MULTIPLIER}, got);
    rd_reg(REG_DIVISOR, got);
    check("divisor reset", {16'h0000, RST_DIVISOR}, got);
    rd_reg(REG_LOWER_BOUND, got);
    check("lower bound reset", NLO, got);
    $display("Test reset done");
    foreach (ROWS[i]) begin
      apply(ROWS[i]);
      check("setpoint_out", ROWS[i].exp, setpoint_out);
      rd_reg(REG_FINAL, got);
      check("final readback", ROWS[i].exp, got);
    end
    $display("Test source and scaling rows done");
    apply(NEUTRAL);
    wr_reg(REG_REL_ADJUST, 32'hFFFF_FFF6);
    idle(8);
    rd_reg(REG_HOST_INPUT, got);
    check("host input after adjust", 32'h0000_005A, got);
    check("setpoint after adjust", 32'h0000_005A, setpoint_out);
    rd_reg(REG_REL_ADJUST, got);
    check("relative adjust readback", 32'hFFFF_FFF6, got);
    $display("Test relative adjust done");
    // Doubling makes a raw step of 5 cross a deadzone of 10 only after scaling.
    apply('{16'h0000, 32'h0000_002D, 16'h0002, 16'h0001, 16'h0000, NLO, NHI, 32'h0});
    wr_reg(REG_DEADZONE, 32'h0000_000A);
    wr_reg(REG_HOST_INPUT, 32'h0000_0031);
    idle(8);
    check("deadzone hold", 32'h0000_005A, setpoint_out);
    wr_reg(REG_HOST_INPUT, 32'h0000_0032);
    idle(8);
    check("deadzone move", 32'h0000_0064, setpoint_out);
    wr_reg(REG_DEADZONE, 32'h0000_0000);
    wr_reg(REG_SOURCE_SEL, 32'h0000_0007);
    wr_reg(REG_HOST_INPUT, 32'h0000_01F4);
    idle(8);
    check("undefined selector hold", 32'h0000_0064, setpoint_out);
    $display("Test deadzone and selector hold done");
    apply(NEUTRAL);
    wr_reg(REG_SMOOTHING, 32'h0000_0001);
    wr_reg(REG_HOST_INPUT, 32'h0000_044C);
    idle(150);
    check_in("smoothed step", 32'h0000_0065, 32'h0000_044B, setpoint_out);
    // Reset in mid-run, while smoothing is on, before the servo pulse begins.
    rst_n <= 1'b0;
    idle(2);
    check("setpoint in reset", 32'h0000_0000, setpoint_out);
    rst_n <= 1'b1;
    idle(2);
    rd_reg(REG_SMOOTHING, got);
    check("smoothing after reset", {16'h0000, RST_SMOOTHING}, got);
    rd_reg(REG_HOST_INPUT, got);
    check("host input after reset", RST_HOST_INPUT, got);
    check("setpoint after reset", 32'h0000_0000, setpoint_out);
    $display("Test mid-run reset done");
    wr_reg(REG_SMOOTHING, 32'h0000_0000);
    $display("Test smoothing done");
    apply('{SEL_PULSE, 32'h0, 16'h0001, 16'h0001, 16'h0000, NLO, NHI, 32'h0});
    while ($time < (START_US + PULSE_US + 5) * 1000) idle(1);
    check_in("pulse setpoint", PULSE_US - PULSE_MIN_US - 1, PULSE_US - PULSE_MIN_US + 1,
             setpoint_out);
    $display("Test servo pulse done");
    report_and_stop;
  end
endmodule // setpoint_source_conditioner_tb_top
`default_nettype wire

// >>> test/sps_far_side.sv
// Purpose: Far-side model: four analog sources, an encoder count and one servo pulse.
// Assumes: Analog and encoder values are steady levels in the bench clock domain.
// Notes:   A single pulse is sent, so its width is known exactly.
`timescale 1ns/1ns
`default_nettype none
module sps_far_side #(
  parameter int unsigned START_US = 10,
  parameter int unsigned PULSE_US = 1003
) (
  output logic [15:0] analog_input_one,
  output logic [15:0] analog_input_two,
  output logic [15:0] analog_input_three,
  output logic [15:0] analog_input_four,
  output logic [31:0] encoder_count,
  output logic        input_pin_one
);
  assign analog_input_one   = 16'hFFFF;
  assign analog_input_two   = 16'h1234;
  assign analog_input_three = 16'h0100;
  assign analog_input_four  = 16'h0042;
  // A negative count shows whether the encoder value keeps its sign.
  assign encoder_count      = 32'hFFFF_FF00;
  // The pin idles low between pulses, as a servo line does.
  initial begin
    input_pin_one = 1'b0;
    #(START_US * 1000);
    input_pin_one = 1'b1;
    #(PULSE_US * 1000);
    input_pin_one = 1'b0;
  end
endmodule // sps_far_side
`default_nettype wire
